// ### obc_option_config.sv
`timescale 1ns/1ps

// What this block does
// - Option bit seven picks the package: one large pin count, zero small.
// - Pads without pins leave reset as inputs with pull-up on.
// - Reset phase and halt exit last 4096 cycles if bit six is 0, else 256.
// - Bits five and four pick resonator, internal RC or external clock; 01 reserved.
// - Bits three to one set resonator drive for the four frequency bands.
// - External clock source forces the drive range to the 2-4 MHz setting.
// - Bit zero at 0 enables the x2 doubler; at 1 bypasses it.
// - Option byte is off the memory map; accessible only in programming mode.
// - Erased option storage reads all ones.
module obc_option_config
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave.
  input wire logic [obc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Asynchronous pins.
  input wire logic prog_mode,
  input wire logic halt_wake,
  // Decoded configuration.
  output logic package_variant_bit,
  output logic reset_phase_length_select,
  output logic [1:0] clock_source_select,
  output logic [2:0] resonator_drive_range,
  output logic doubler_enable,
  output logic [obc_pkg::PAD_COUNT-1:0] unbonded_pad_pullup,
  output logic cpu_hold
);

  // Whole block state; the latched settings double as the output registers.
  typedef struct packed {
    // Option storage and the hold sequencer.
    logic [7:0] opt_store;
    obc_pkg::obc_phase_t phase;
    logic [obc_pkg::HOLD_CNT_W-1:0] hold_count;
    logic cpu_hold;

    // Latched configuration, frozen outside the reset phase.
    logic package_variant_bit;
    logic reset_phase_length_select;
    logic [1:0] clock_source_select;
    logic [2:0] resonator_drive_range;
    logic doubler_enable;
    logic [obc_pkg::PAD_COUNT-1:0] unbonded_pad_pullup;

    // Halt wake edge detector and the bus slave registers.
    logic wake_prev;
    logic waitrequest;
    logic [31:0] readdata;
  } obc_state_t;

  // Reset state mirrors what an erased option byte decodes to.
  // Outputs therefore show the erased decode until the first reset phase has run.
  localparam obc_state_t RESET_STATE = '{
    opt_store: obc_pkg::OPT_ERASED,
    phase: obc_pkg::OBC_PH_RESET,
    hold_count: obc_pkg::HOLD_CNT_ZERO,
    cpu_hold: 1'b1,
    package_variant_bit: 1'b1,
    reset_phase_length_select: 1'b1,
    clock_source_select: obc_pkg::SRC_EXTERNAL,
    resonator_drive_range: obc_pkg::mid_band_setting,
    doubler_enable: 1'b0,
    unbonded_pad_pullup: obc_pkg::UNBONDED_LARGE_PKG,
    wake_prev: 1'b0,
    waitrequest: 1'b1,
    readdata: 32'h0000_0000
  };

  // Registered state and the value it takes at the next edge.
  obc_state_t cur;
  obc_state_t next_cur;

  // Pin levels after the synchroniser; nothing here reads the raw pins.
  logic [obc_pkg::SYNC_W-1:0] pins_sync;
  logic prog_active;
  logic wake_level;

  // Address decode shared by the read and the write paths.
  function automatic obc_pkg::obc_sel_t reg_select(input logic [obc_pkg::ADDR_W-1:0] addr);
    obc_pkg::obc_sel_t sel;
    // Unlisted offsets decode to no register, so they read zero and ignore writes.
    sel = obc_pkg::OBC_SEL_NONE;
    if (addr == obc_pkg::REG_OPTION)
    begin
      sel = obc_pkg::OBC_SEL_OPTION;
    end
    else if (addr == obc_pkg::REG_CONTROL)
    begin
      sel = obc_pkg::OBC_SEL_CONTROL;
    end
    else if (addr == obc_pkg::REG_STATUS)
    begin
      sel = obc_pkg::OBC_SEL_STATUS;
    end
    return sel;
  endfunction : reg_select

  // Last count value of the hold phase for a given length select.
  // Counting from zero up to this value keeps the hold for the full cycle count.
  function automatic logic [obc_pkg::HOLD_CNT_W-1:0] hold_last(input logic len_sel);
    return len_sel ? obc_pkg::HOLD_SHORT_LAST : obc_pkg::HOLD_LONG_LAST;
  endfunction : hold_last

  // Effective drive range: an external clock always runs the mid setting.
  // The stored field is kept, so a later switch back to the resonator still sees it.
  function automatic logic [2:0] eff_range(input logic [1:0] src, input logic [2:0] rng);
    return (src == obc_pkg::SRC_EXTERNAL) ? obc_pkg::mid_band_setting : rng;
  endfunction : eff_range

  // Both pins come from outside the clock domain.
  // Three stages cost a few cycles of latency on mode changes, which software never notices.
  obc_sync3 u_sync
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({halt_wake, prog_mode}),
    .sync_out(pins_sync)
  );

  // Named views of the synchronised pins.
  assign prog_active = pins_sync[obc_pkg::SYNC_PROG];
  assign wake_level = pins_sync[obc_pkg::SYNC_WAKE];

  // Bus slave, hold sequencer and configuration latch.
  always_comb
  begin
    logic [7:0] opt;
    logic restart;
    logic warn;
    logic [31:0] status;
    obc_pkg::obc_sel_t sel;
    // Defaults first, so that every path assigns every variable.
    next_cur = cur;
    opt = cur.opt_store;
    restart = 1'b0;
    warn = 1'b0;
    status = 32'h0000_0000;
    sel = reg_select(address);

    // The wake edge detector samples every cycle, also while a hold runs.
    next_cur.wake_prev = wake_level;

    // The warning only reports; the doubler still follows the stored byte.
    // Doubler requested where its operation is not assured.
    warn = cur.doubler_enable &&
           ((cur.clock_source_select == obc_pkg::SRC_INTERNAL_RC) ||
            (cur.resonator_drive_range != obc_pkg::mid_band_setting));

    // Status word: a live view of the latched settings and the programming pin.
    status[obc_pkg::STS_HOLD_BIT] = cur.cpu_hold;
    status[obc_pkg::STS_PROG_BIT] = prog_active;
    status[obc_pkg::STS_PKG_BIT] = cur.package_variant_bit;
    status[obc_pkg::STS_RSTLEN_BIT] = cur.reset_phase_length_select;
    status[obc_pkg::STS_SRC_LO +: 2] = cur.clock_source_select;
    status[obc_pkg::STS_RANGE_LO +: 3] = cur.resonator_drive_range;
    status[obc_pkg::STS_DBL_BIT] = cur.doubler_enable;
    status[obc_pkg::STS_WARN_BIT] = warn;

    // One wait cycle per access; the access completes while waitrequest is low.
    // Refused and unmapped reads answer zero rather than stale data.
    if ((read || write) && cur.waitrequest)
    begin
      next_cur.waitrequest = 1'b0;
      next_cur.readdata = 32'h0000_0000;
      if (read && (sel == obc_pkg::OBC_SEL_OPTION) && prog_active)
      begin
        next_cur.readdata[obc_pkg::OPT_WIDTH-1:0] = cur.opt_store;
      end
      else if (read && (sel == obc_pkg::OBC_SEL_STATUS))
      begin
        next_cur.readdata = status;
      end
    end
    else
    begin
      next_cur.waitrequest = 1'b1;
    end

    // Writes land on the edge where waitrequest is seen low.
    // Outside programming mode a write is answered but changes nothing.
    if (write && !cur.waitrequest && prog_active)
    begin
      if (sel == obc_pkg::OBC_SEL_OPTION)
      begin
        next_cur.opt_store = writedata[obc_pkg::OPT_WIDTH-1:0];
      end
      else if (sel == obc_pkg::OBC_SEL_CONTROL)
      begin
        // Only bit zero has a meaning; the other bits are ignored.
        restart = writedata[obc_pkg::CTRL_RESTART_BIT];
      end
    end

    // Hold sequencer: reset phase, run, and the delay on leaving halt.
    case (cur.phase)
      obc_pkg::OBC_PH_RESET:
      begin
        // Settings follow the stored byte only while the reset phase runs.
        next_cur.package_variant_bit = opt[obc_pkg::OPT_PKG_BIT];
        next_cur.reset_phase_length_select = opt[obc_pkg::OPT_RSTLEN_BIT];
        next_cur.clock_source_select = opt[obc_pkg::OPT_SRC_HI:obc_pkg::OPT_SRC_LO];
        next_cur.resonator_drive_range =
          eff_range(opt[obc_pkg::OPT_SRC_HI:obc_pkg::OPT_SRC_LO], opt[obc_pkg::OPT_RANGE_HI:obc_pkg::OPT_RANGE_LO]);
        next_cur.doubler_enable = !opt[obc_pkg::OPT_DBL_OFF_BIT];

        // Unbonded pads stay forced to input with pull-up; software cannot undo it.
        next_cur.unbonded_pad_pullup = opt[obc_pkg::OPT_PKG_BIT] ?
          obc_pkg::UNBONDED_LARGE_PKG : obc_pkg::UNBONDED_SMALL_PKG;

        // The length follows the live byte, so a write during the phase applies at once.
        if (cur.hold_count == hold_last(opt[obc_pkg::OPT_RSTLEN_BIT]))
        begin
          next_cur.phase = obc_pkg::OBC_PH_RUN;
          next_cur.cpu_hold = 1'b0;
          next_cur.hold_count = obc_pkg::HOLD_CNT_ZERO;
        end
        else
        begin
          next_cur.hold_count = cur.hold_count + obc_pkg::HOLD_CNT_ONE;
        end
      end
      obc_pkg::OBC_PH_RUN:
      begin
        // A wake from halt reuses the length latched at the last reset.
        // Wakes are refused while a hold runs, since only this phase looks at them.
        if (wake_level && !cur.wake_prev)
        begin
          next_cur.phase = obc_pkg::OBC_PH_HALT_EXIT;
          next_cur.cpu_hold = 1'b1;
          next_cur.hold_count = obc_pkg::HOLD_CNT_ZERO;
        end
      end
      obc_pkg::OBC_PH_HALT_EXIT:
      begin
        // Same count as the reset phase, but the settings stay frozen.
        if (cur.hold_count == hold_last(cur.reset_phase_length_select))
        begin
          next_cur.phase = obc_pkg::OBC_PH_RUN;
          next_cur.cpu_hold = 1'b0;
          next_cur.hold_count = obc_pkg::HOLD_CNT_ZERO;
        end
        else
        begin
          next_cur.hold_count = cur.hold_count + obc_pkg::HOLD_CNT_ONE;
        end
      end
      default:
      begin
        // An unused phase code returns to the reset phase rather than hanging; cpu_hold and hold_count keep their values.
        next_cur.phase = obc_pkg::OBC_PH_RESET;
      end
    endcase

    // A software restart reruns the reset phase and relatches the byte.
    // It comes last so that it wins over the sequencer's own step.
    if (restart)
    begin
      next_cur.phase = obc_pkg::OBC_PH_RESET;
      next_cur.cpu_hold = 1'b1;
      next_cur.hold_count = obc_pkg::HOLD_CNT_ZERO;
    end
  end

  // Storage resets to the erased value, so a blank part powers up with all ones.
  // The reset branch loads constants only; nothing from the bus reaches it.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= RESET_STATE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Every output is a state field.
  // No output passes through logic after its flip-flop.
  assign readdata = cur.readdata;
  assign waitrequest = cur.waitrequest;
  assign package_variant_bit = cur.package_variant_bit;
  assign reset_phase_length_select = cur.reset_phase_length_select;
  assign clock_source_select = cur.clock_source_select;
  assign resonator_drive_range = cur.resonator_drive_range;
  assign doubler_enable = cur.doubler_enable;
  assign unbonded_pad_pullup = cur.unbonded_pad_pullup;
  assign cpu_hold = cur.cpu_hold;

endmodule : obc_option_config

// ### obc_pkg.sv
package obc_pkg;

  // Option byte storage and its erased value.
  localparam int OPT_WIDTH = 8;
  localparam logic [7:0] OPT_ERASED = 8'hFF;

  // Option byte field positions.
  localparam int OPT_PKG_BIT = 7;
  localparam int OPT_RSTLEN_BIT = 6;
  localparam int OPT_SRC_HI = 5;
  localparam int OPT_SRC_LO = 4;
  localparam int OPT_RANGE_HI = 3;
  localparam int OPT_RANGE_LO = 1;
  localparam int OPT_DBL_OFF_BIT = 0;

  // Clock source codes.
  localparam logic [1:0] SRC_RESONATOR = 2'h0;
  localparam logic [1:0] SRC_RESERVED = 2'h1;
  localparam logic [1:0] SRC_INTERNAL_RC = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;

  // Resonator drive range codes.
  localparam logic [2:0] low_band_setting = 3'h0;
  localparam logic [2:0] mid_band_setting = 3'h1;
  localparam logic [2:0] upper_mid_band_setting = 3'h2;
  localparam logic [2:0] high_band_setting = 3'h3;

  // Reset phase lengths in CPU cycles, stored as last count value.
  localparam int HOLD_CNT_W = 13;
  localparam logic [12:0] HOLD_LONG_LAST = 13'h0FFF;
  localparam logic [12:0] HOLD_SHORT_LAST = 13'h00FF;
  localparam logic [12:0] HOLD_CNT_ZERO = 13'h0000;
  localparam logic [12:0] HOLD_CNT_ONE = 13'h0001;

  // Pads: four ports of eight pads each; bit set means pad is not bonded.
  localparam int PAD_COUNT = 32;
  localparam logic [31:0] UNBONDED_LARGE_PKG = 32'h0000_0000;
  localparam logic [31:0] UNBONDED_SMALL_PKG = 32'hFF00_0000;

  // Register map, byte addresses on the Avalon slave.
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_OPTION = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CTRL_RESTART_BIT = 0;

  // Status register field positions.
  localparam int STS_HOLD_BIT = 0;
  localparam int STS_PROG_BIT = 1;
  localparam int STS_PKG_BIT = 2;
  localparam int STS_RSTLEN_BIT = 3;
  localparam int STS_SRC_LO = 4;
  localparam int STS_RANGE_LO = 6;
  localparam int STS_DBL_BIT = 9;
  localparam int STS_WARN_BIT = 10;

  // Synchronised pin inputs: bit 0 programming mode, bit 1 halt wake.
  localparam int SYNC_W = 2;
  localparam int SYNC_PROG = 0;
  localparam int SYNC_WAKE = 1;

  // Address decode result.
  typedef enum logic [1:0] {OBC_SEL_NONE, OBC_SEL_OPTION, OBC_SEL_CONTROL, OBC_SEL_STATUS} obc_sel_t;

  // Hold phase of the CPU.
  typedef enum logic [1:0] {OBC_PH_RESET, OBC_PH_RUN, OBC_PH_HALT_EXIT} obc_phase_t;

endpackage : obc_pkg

// ### obc_sva.sv
`timescale 1ns/1ps

module obc_sva
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bus.
  input wire logic [obc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Decoded configuration.
  input wire logic package_variant_bit,
  input wire logic reset_phase_length_select,
  input wire logic [1:0] clock_source_select,
  input wire logic [2:0] resonator_drive_range,
  input wire logic doubler_enable,
  input wire logic [obc_pkg::PAD_COUNT-1:0] unbonded_pad_pullup,
  input wire logic cpu_hold
);
  logic [12:0] hold_cnt;

  // Counts hold cycles; a restart inside a phase would stretch it, so benches avoid that.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      hold_cnt <= 13'h0000;
    else if (cpu_hold)
      hold_cnt <= hold_cnt + 13'h0001;
    else
      hold_cnt <= 13'h0000;
  end

  // All checks share one clock and the reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    (read || write) && waitrequest;
  endsequence
  sequence s_ans;
    !waitrequest;
  endsequence

  answer_next_a: assert property (s_take |=> s_ans) else $error("Access not answered in next cycle.");
  wait_pulse_a: assert property (s_ans |=> waitrequest) else $error("Answer longer than one cycle.");
  unmapped_zero_a: assert property (s_take ##0 (read && address > obc_pkg::REG_STATUS) |=>
    s_ans ##0 (readdata == 32'h0)) else $error("Unmapped read not zero.");
  status_map_a: assert property (s_take ##0 (read && address == obc_pkg::REG_STATUS && !cpu_hold) |=>
    readdata[obc_pkg::STS_PKG_BIT] == package_variant_bit && readdata[obc_pkg::STS_SRC_LO+:2] == clock_source_select
    && readdata[obc_pkg::STS_DBL_BIT] == doubler_enable) else $error("Status does not match outputs.");
  erased_cfg_a: assert property ($rose(reset_n) |-> package_variant_bit && reset_phase_length_select
    && clock_source_select == 2'h3 && !doubler_enable) else $error("Erased settings wrong after reset.");
  pad_mask_a: assert property (!cpu_hold |-> unbonded_pad_pullup == (package_variant_bit ?
    obc_pkg::UNBONDED_LARGE_PKG : obc_pkg::UNBONDED_SMALL_PKG)) else $error("Pad mask wrong for package.");
  ext_range_a: assert property (!cpu_hold && clock_source_select == 2'h3 |-> resonator_drive_range == 3'h1)
    else $error("External source range not mid band.");
  cfg_frozen_a: assert property (!cpu_hold ##1 !cpu_hold |-> $stable({package_variant_bit,
    reset_phase_length_select, clock_source_select, resonator_drive_range, doubler_enable}))
    else $error("Settings changed outside reset phase.");
  hold_len_a: assert property ($fell(cpu_hold) |-> hold_cnt - (reset_phase_length_select ? 13'h0100 :
    13'h1000) <= 13'h0001) else $error("Hold phase length wrong.");
endmodule : obc_sva

bind obc_option_config obc_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest), .package_variant_bit(package_variant_bit),
  .reset_phase_length_select(reset_phase_length_select), .clock_source_select(clock_source_select),
  .resonator_drive_range(resonator_drive_range), .doubler_enable(doubler_enable),
  .unbonded_pad_pullup(unbonded_pad_pullup), .cpu_hold(cpu_hold));

// ### obc_sync3.sv
`timescale 1ns/1ps

module obc_sync3
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Asynchronous levels in, filtered levels out.
  input wire logic [obc_pkg::SYNC_W-1:0] async_in,
  output logic [obc_pkg::SYNC_W-1:0] sync_out
);

  typedef struct packed {
    logic [obc_pkg::SYNC_W-1:0] stage1;
    logic [obc_pkg::SYNC_W-1:0] stage2;
    logic [obc_pkg::SYNC_W-1:0] stage3;
    logic [obc_pkg::SYNC_W-1:0] level;
  } obc_sync_state_t;

  obc_sync_state_t cur;
  obc_sync_state_t next_cur;

  // The first stage feeds only the second; a bit changes once stages two and three agree.
  always_comb
  begin
    next_cur = cur;
    next_cur.stage1 = async_in;
    next_cur.stage2 = cur.stage1;
    next_cur.stage3 = cur.stage2;
    for (int i = 0; i < obc_pkg::SYNC_W; i++)
    begin
      if (cur.stage2[i] == cur.stage3[i])
      begin
        next_cur.level[i] = cur.stage3[i];
      end
    end
  end

  // Register the whole state.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.level;

endmodule : obc_sync3

// ### tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic prog_mode = 1'b0;
  logic halt_wake = 1'b0;
  logic package_variant_bit;
  logic reset_phase_length_select;
  logic [1:0] clock_source_select;
  logic [2:0] resonator_drive_range;
  logic doubler_enable;
  logic [31:0] unbonded_pad_pullup;
  logic cpu_hold;
  logic [31:0] q;
  logic [2:0] rng;
  int mismatches = 0;
  int n_tests = 0;
  logic [7:0] vals [5] = '{8'h01, 8'hD3, 8'hE7, 8'hF5, 8'h02};

  // A 40 ns period clock.
  always #20 sys_clk = ~sys_clk;

  obc_option_config u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .prog_mode(prog_mode), .halt_wake(halt_wake), .package_variant_bit(package_variant_bit),
    .reset_phase_length_select(reset_phase_length_select), .clock_source_select(clock_source_select),
    .resonator_drive_range(resonator_drive_range), .doubler_enable(doubler_enable),
    .unbonded_pad_pullup(unbonded_pad_pullup), .cpu_hold(cpu_hold));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One access; the leading edge keeps a new request off the step of the last release.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do
    begin
      @(posedge sys_clk);
      t++;
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Taken at the first edge, answered with waitrequest low at the second.
    check("answer cycles", t, 32'h2);
  endtask : bus

  task automatic rd(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask : rd

  // Counts hold cycles; one extra cycle of launch latency is tolerated.
  task automatic hold_len(input int n_exp);
    int n;
    n = 0;
    for (int i = 0; i < 12 && cpu_hold !== 1'b1; i++)
      @(posedge sys_clk);
    while (cpu_hold === 1'b1 && n < 5000)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("hold length", {31'h0, n >= n_exp && n <= n_exp + 1}, 32'h1);
  endtask : hold_len

  task automatic cfg(input logic [7:0] v);
    check("package", {31'h0, package_variant_bit}, {31'h0, v[7]});
    check("length", {31'h0, reset_phase_length_select}, {31'h0, v[6]});
    check("source", {30'h0, clock_source_select}, {30'h0, v[5:4]});
    check("range", {29'h0, resonator_drive_range}, {29'h0, v[5:4] == 2'h3 ? 3'h1 : v[3:1]});
    check("doubler", {31'h0, doubler_enable}, {31'h0, !v[0]});
    check("pads", unbonded_pad_pullup, v[7] ? 32'h0 : 32'hFF00_0000);
  endtask : cfg

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // Main sequence: erased start, each option value, wake, refusal and a second reset.
  initial
  begin
    repeat (2) @(posedge sys_clk);
    cfg(8'hFF);
    reset_n <= 1'b1;
    hold_len(256);
    rd("option", 4'h0, 32'h0);
    rd("unmapped", 4'hC, 32'h0);
    prog_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd("option", 4'h0, 32'hFF);
    foreach (vals[i])
    begin
      bus(1'b1, 4'h0, {24'h0, vals[i]});
      rd("option", 4'h0, {24'h0, vals[i]});
      bus(1'b1, 4'h4, 32'h1);
      hold_len(vals[i][6] ? 256 : 4096);
      cfg(vals[i]);
      rng = (vals[i][5:4] == 2'h3) ? 3'h1 : vals[i][3:1];
      rd("status", 4'h8, {21'h0, 1'b0, ~vals[i][0], rng, vals[i][5:4], vals[i][6], vals[i][7], 2'h2});
    end
    bus(1'b1, 4'h0, 32'h01);
    cfg(8'h02);
    halt_wake <= 1'b1;
    hold_len(4096);
    halt_wake <= 1'b0;
    prog_mode <= 1'b0;
    repeat (5) @(posedge sys_clk);
    bus(1'b1, 4'h0, 32'hA9);
    prog_mode <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd("option", 4'h0, 32'h01);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd("option", 4'h0, 32'hFF);
    stop_test();
  end

  // Cuts a hang short; the tests need about 14000 cycles.
  initial
  begin
    #800000;
    mismatches++;
    stop_test();
  end
endmodule : tb_top
